// ### core/external_memory_bus_interface.sv
// External memory bus sequencer: code fetch, data read and data write on multiplexed ports
//
// Contract
// - A low external-access select sends every code fetch to the external memory.
// - With the select high and the address in on-chip code space, no bus cycle is run.
// - External fetches and code-table reads pulse the program-store strobe low.
// - Internal code accesses produce no program-store strobe pulse.
// - The address latch strobe lets an outside latch capture the low address byte.
// - The low port carries the low address byte first and the data byte after it.
// - The high port carries the upper address byte during external accesses.
// - Data writes use the write strobe and data reads the read strobe, both active low.
// - Program and data spaces are each 64K bytes, addressed with 16 bits.
// - With the latch strobe turned off, it still pulses for each external access.
`timescale 1ns/1ps
module external_memory_bus_interface
    import ext_bus_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic                  externalAccessSelect,
    input  wire logic                  aleOff,
    input  wire logic                  codeReq,
    input  wire logic                  dataReadReq,
    input  wire logic                  dataWriteReq,
    input  wire logic [ADDR_WIDTH-1:0] reqAddress,
    input  wire logic [DATA_WIDTH-1:0] writeData,
    output logic                       reqReady,
    output logic                       done,
    output logic                       doneInternal,
    output logic      [DATA_WIDTH-1:0] readData,
    input  wire logic [DATA_WIDTH-1:0] lowPortIn,
    output logic      [DATA_WIDTH-1:0] lowPortOut,
    output logic                       lowPortOeN,
    output logic      [DATA_WIDTH-1:0] highPortOut,
    output logic                       addressLatchStrobe,
    output logic                       programStoreStrobeN,
    output logic                       writeStrobeN,
    output logic                       readStrobeN
);

    state_type             state;
    state_type             next_state;
    logic                  eaSync;
    logic [DATA_WIDTH-1:0] lowSync;
    logic [2:0]            strobeCount;
    logic [2:0]            aleCount;
    logic                  kindCode;
    logic                  kindRead;
    logic                  kindWrite;
    logic [ADDR_WIDTH-1:0] addrReg;
    logic [DATA_WIDTH-1:0] wdataReg;
    logic                  anyReq;
    logic                  inOnChip;
    logic                  internalAccept;
    logic                  externalAccept;
    logic                  strobeLast;
    logic                  idleAlePulse;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    sync_stage #(.WIDTH(1)) eaSyncInst (
        .clock   (clock),
        .reset   (reset),
        .asyncIn (externalAccessSelect),
        .syncOut (eaSync)
    );

    sync_stage #(.WIDTH(DATA_WIDTH)) lowSyncInst (
        .clock   (clock),
        .reset   (reset),
        .asyncIn (lowPortIn),
        .syncOut (lowSync)
    );

    // ****************************************
    // Request decode
    // ****************************************
    // Code wins over data read, data read over data write when several arrive together
    assign reqReady       = (state == S_IDLE);
    assign anyReq         = codeReq | dataReadReq | dataWriteReq;
    assign inOnChip       = ({1'b0, reqAddress} < ON_CHIP_CODE_SIZE);
    assign internalAccept = reqReady & codeReq & eaSync & inOnChip;
    assign externalAccept = reqReady & anyReq & ~internalAccept;
    assign strobeLast     = (strobeCount == STROBE_CLOCKS - 3'h1);
    assign idleAlePulse   = (aleCount == ALE_IDLE_PERIOD - 3'h1);

    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE:   if (externalAccept) next_state = S_ADDR;
            S_ADDR:   next_state = S_LATCH;
            S_LATCH:  next_state = S_STROBE;
            S_STROBE: if (strobeLast) next_state = S_FINISH;
            S_FINISH: next_state = S_IDLE;
            default:  next_state = S_IDLE;
        endcase
    end

    // Sequencer state; reset length is the outside party's duty
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Strobe width counter
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            strobeCount <= 3'h0;
        end else if (state == S_STROBE) begin
            strobeCount <= strobeCount + 3'h1;
        end else begin
            strobeCount <= 3'h0;
        end
    end

    // Idle latch pulse divider, free running only while no access is under way
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            aleCount <= 3'h0;
        end else if (state != S_IDLE || idleAlePulse) begin
            aleCount <= 3'h0;
        end else begin
            aleCount <= aleCount + 3'h1;
        end
    end

    // Capture of the accepted access
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            kindCode  <= 1'b0;
            kindRead  <= 1'b0;
            kindWrite <= 1'b0;
            addrReg   <= 16'h0000;
            wdataReg  <= 8'h00;
        end else if (externalAccept) begin
            kindCode  <= codeReq;
            kindRead  <= ~codeReq & dataReadReq;
            kindWrite <= ~codeReq & ~dataReadReq;
            addrReg   <= reqAddress;
            wdataReg  <= writeData;
        end
    end

    // ****************************************
    // Bus pins, registered from the next state
    // ****************************************
    // Low port: address byte first, then write data or released for read data
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            lowPortOut  <= 8'hFF;
            lowPortOeN  <= 1'b1;
            highPortOut <= 8'hFF;
        end else begin
            if (externalAccept) begin
                lowPortOut  <= reqAddress[7:0];
                highPortOut <= reqAddress[15:8];
            end else if (state == S_LATCH) begin
                lowPortOut  <= wdataReg;
            end
            // Address stays driven through the latch state, so the turn comes after the fall
            lowPortOeN <= ~((next_state == S_ADDR) || (next_state == S_LATCH) ||
                            (kindWrite && (next_state == S_STROBE ||
                                           next_state == S_FINISH)));
        end
    end

    // Latch strobe: forced on for an external access even while turned off
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            addressLatchStrobe <= 1'b0;
        end else begin
            addressLatchStrobe <= (next_state == S_ADDR) ||
                                  (next_state == S_IDLE && idleAlePulse && !aleOff);
        end
    end

    // Active low read, write and program-store strobes
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            programStoreStrobeN <= 1'b1;
            readStrobeN         <= 1'b1;
            writeStrobeN        <= 1'b1;
        end else begin
            programStoreStrobeN <= ~(next_state == S_STROBE && kindCode);
            readStrobeN         <= ~(next_state == S_STROBE && kindRead);
            writeStrobeN        <= ~(next_state == S_STROBE && kindWrite);
        end
    end

    // ****************************************
    // Answer to the core
    // ****************************************
    // Read data is taken from the synchronised port at the strobe's last clock
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            readData     <= 8'h00;
            done         <= 1'b0;
            doneInternal <= 1'b0;
        end else begin
            if (state == S_STROBE && strobeLast && !kindWrite) begin
                readData <= lowSync;
            end
            done         <= (state == S_FINISH) || internalAccept;
            doneInternal <= internalAccept;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_INTERNAL_QUIET: assert property (
        internalAccept |=> (state == S_IDLE) && programStoreStrobeN && lowPortOeN
                           && done && doneInternal)
        else $error("internal code access disturbed the external bus");

    AST_EA_LOW_EXTERNAL: assert property (
        (reqReady && codeReq && !eaSync) |=> (state == S_ADDR) && addressLatchStrobe)
        else $error("code request with select low did not start an external cycle");

    AST_CODE_STROBE: assert property (
        (state == S_LATCH && kindCode) |=> (!programStoreStrobeN) [*4] ##1 programStoreStrobeN)
        else $error("program-store strobe width wrong");

    AST_ALE_ADDRESS: assert property (
        (state == S_ADDR) |-> addressLatchStrobe && !lowPortOeN
                              && (lowPortOut == addrReg[7:0]))
        else $error("latch strobe not high with low address driven");

    AST_ADDR_HOLD: assert property (
        (state == S_LATCH) |-> !addressLatchStrobe && !lowPortOeN
                               && (lowPortOut == $past(lowPortOut)))
        else $error("low address not held after latch strobe fall");

    AST_HIGH_BYTE: assert property (
        (state != S_IDLE) |-> (highPortOut == addrReg[15:8]))
        else $error("upper address byte not on high port");

    AST_WRITE_CYCLE: assert property (
        (state == S_STROBE && kindWrite) |-> !writeStrobeN && readStrobeN
                                             && !lowPortOeN && (lowPortOut == wdataReg))
        else $error("write strobe or write data wrong");

    AST_READ_CYCLE: assert property (
        (state == S_STROBE && kindRead) |-> !readStrobeN && writeStrobeN && lowPortOeN)
        else $error("read strobe or port release wrong");

    AST_ALE_OFF: assert property (
        (state == S_IDLE && $past(state) == S_IDLE && $past(aleOff)) |-> !addressLatchStrobe)
        else $error("latch strobe pulsed while turned off and idle");

    AST_DONE_LATENCY: assert property (
        externalAccept |-> ##8 done)
        else $error("external access answer not eight clocks later");

    COV_CODE_FETCH: cover property (externalAccept && codeReq);
    COV_DATA_READ:  cover property (state == S_FINISH && kindRead);
    COV_DATA_WRITE: cover property (state == S_FINISH && kindWrite);
    COV_INTERNAL:   cover property (internalAccept);

endmodule : external_memory_bus_interface

// ### core/ext_bus_pkg.sv
// Constants and types shared by the external memory bus interface
package ext_bus_pkg;

    // ****************************************
    // Address space and on-chip code size
    // ****************************************
    localparam int          ADDR_WIDTH        = 16;            // 64K program, 64K data
    localparam int          DATA_WIDTH        = 8;
    localparam logic [16:0] ON_CHIP_CODE_SIZE = 17'h0_2000;    // 8K bytes of on-chip code

    // ****************************************
    // Timing
    // ****************************************
    localparam int          CLOCK_PERIOD_NS    = 50;           // 20 MHz core clock
    localparam int          MACHINE_CYCLE_OSC  = 12;           // Oscillator periods per cycle
    localparam int          MIN_RESET_MACHINES = 2;            // Reset held high this long
    localparam int          MIN_RESET_CLOCKS   = MIN_RESET_MACHINES * MACHINE_CYCLE_OSC;
    localparam int          STROBE_NS          = 200;          // Least read/write strobe width
    localparam int          STROBE_CLOCKS_INT  =
        (STROBE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [2:0]  STROBE_CLOCKS      = 3'(STROBE_CLOCKS_INT);
    localparam logic [2:0]  ALE_IDLE_PERIOD    = 3'h6;         // Two latch pulses per cycle

    // ****************************************
    // Bus sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_ADDR   = 3'b001,
        S_LATCH  = 3'b010,
        S_STROBE = 3'b011,
        S_FINISH = 3'b100
    } state_type;

endpackage : ext_bus_pkg

// ### core/sync_stage.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync_stage #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] firstStage;

    // First stage feeds only the second, to let metastability settle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            firstStage <= '0;
            syncOut    <= '0;
        end else begin
            firstStage <= asyncIn;
            syncOut    <= firstStage;
        end
    end

endmodule : sync_stage

// ### bench/ext_memory_model.sv
// Behavioural external program and data memory with its address latch
`timescale 1ns/1ps
module ext_memory_model (
    input  wire logic        clock,
    input  wire logic        addressLatchStrobe,
    input  wire logic [7:0]  lowPortWire,
    input  wire logic [7:0]  highPortOut,
    input  wire logic        programStoreStrobeN,
    input  wire logic        readStrobeN,
    input  wire logic        writeStrobeN,
    input  wire logic        slow,
    output logic             memOe,
    output logic      [7:0]  memOut,
    output logic      [15:0] latchedAddr
);
    logic [7:0] lowLatch;
    logic       strobeSeen;
    logic [7:0] dataMem [0:65535];

    // ****************************************
    // Address latch and memory
    // ****************************************
    // Unwritten cells read as a fixed filler so a stale bus value never passes
    initial begin
        foreach (dataMem[i]) dataMem[i] = 8'hEE;
    end
    // Latch closes as the strobe falls, so the port must still hold the address
    always @(negedge addressLatchStrobe) begin
        lowLatch <= lowPortWire;
    end
    assign latchedAddr = {highPortOut, lowLatch};
    // Slow mode answers one clock late, still inside the allowed window
    always @(posedge clock) begin
        strobeSeen <= !(programStoreStrobeN && readStrobeN);
    end
    assign memOe = !(programStoreStrobeN && readStrobeN) && (!slow || strobeSeen);
    assign memOut = !programStoreStrobeN ? (latchedAddr[7:0] ^ latchedAddr[15:8] ^ 8'h5A)
                                         : dataMem[latchedAddr];
    // Write data is taken at the trailing edge of the write strobe
    always @(posedge writeStrobeN) begin
        dataMem[latchedAddr] = lowPortWire;
    end
endmodule : ext_memory_model

// ### bench/external_memory_bus_interface_tb_top.sv
// Self-checking bench for the external memory bus interface
`timescale 1ns/1ps
module external_memory_bus_interface_tb_top;
    import ext_bus_pkg::*;
    logic clock, reset, externalAccessSelect, aleOff, codeReq, dataReadReq, dataWriteReq;
    logic reqReady, done, doneInternal, lowPortOeN, addressLatchStrobe, slow, memOe, aleLast;
    logic programStoreStrobeN, writeStrobeN, readStrobeN;
    logic [15:0] reqAddress, latchedAddr;
    logic [7:0]  writeData, readData, lowPortIn, lowPortOut, highPortOut, memOut, lastWire;
    int n_mismatch, n_checks, cycles, psenCnt, rdCnt, wrCnt, aleCnt, oeCnt;

    external_memory_bus_interface u_dut (.clock(clock), .reset(reset),
        .externalAccessSelect(externalAccessSelect), .aleOff(aleOff), .codeReq(codeReq),
        .dataReadReq(dataReadReq), .dataWriteReq(dataWriteReq), .reqAddress(reqAddress),
        .writeData(writeData), .reqReady(reqReady), .done(done), .doneInternal(doneInternal),
        .readData(readData), .lowPortIn(lowPortIn), .lowPortOut(lowPortOut),
        .lowPortOeN(lowPortOeN), .highPortOut(highPortOut),
        .addressLatchStrobe(addressLatchStrobe), .programStoreStrobeN(programStoreStrobeN),
        .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN));
    ext_memory_model u_mem (.clock(clock), .addressLatchStrobe(addressLatchStrobe),
        .lowPortWire(lowPortIn), .highPortOut(highPortOut),
        .programStoreStrobeN(programStoreStrobeN), .readStrobeN(readStrobeN),
        .writeStrobeN(writeStrobeN), .slow(slow), .memOe(memOe), .memOut(memOut),
        .latchedAddr(latchedAddr));

    // ****************************************
    // Wire, clock and monitors
    // ****************************************
    // A released port shows a changing pattern, never the last driven byte
    assign lowPortIn = !lowPortOeN ? lowPortOut : memOe ? memOut : ~lastWire;
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Strobe activity is counted per access and judged when it completes
    always @(posedge clock) begin
        lastWire <= lowPortIn;
        psenCnt += !programStoreStrobeN;
        rdCnt += !readStrobeN;
        wrCnt += !writeStrobeN;
        oeCnt += !lowPortOeN;
        aleCnt += addressLatchStrobe && !aleLast;
        aleLast <= addressLatchStrobe;
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            stop_test();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // Kind 0 code, 1 data read, 2 data write; latency 1 means on-chip code
    task automatic access(input int kind, input logic [15:0] addr, input logic [7:0] wd,
                          input int lat, input logic [7:0] expData);
        int n;
        n = 0;
        // Let one edge pass so a request never rises where the last one fell
        do begin
            @(negedge clock);
            n++;
        end while (reqReady !== 1'b1 && n < 20);
        {codeReq, dataReadReq, dataWriteReq} = {kind == 0, kind == 1, kind == 2};
        reqAddress = addr;
        writeData = wd;
        {psenCnt, rdCnt, wrCnt, aleCnt, oeCnt} = '0;
        @(negedge clock);
        {codeReq, dataReadReq, dataWriteReq} = 3'b000;
        // An internal answer stands only in the first cycle after the request
        n = 1;
        while (done !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        check(16'(n), 16'(lat));
        check(reqReady, 1'b1);
        check(doneInternal, lat == 1);
        check(16'(oeCnt), lat == 1 ? 0 : kind == 2 ? 7 : 2);
        check(16'(psenCnt), (kind == 0 && lat > 1) ? 4 : 0);
        check(16'(rdCnt), kind == 1 ? 4 : 0);
        check(16'(wrCnt), kind == 2 ? 4 : 0);
        check(16'(aleCnt), lat > 1);
        if (lat > 1) begin
            check(latchedAddr, addr);
            check(highPortOut, addr[15:8]);
            if (kind != 2) check(readData, expData);
        end
    endtask : access

    task automatic set_select(input logic v);
        externalAccessSelect = v;
        repeat (3) @(negedge clock);
    endtask : set_select

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_internal();
        set_select(1'b1);
        access(0, 16'h1FFF, 8'h00, 1, 8'h00);
        access(0, 16'h0000, 8'h00, 1, 8'h00);
    endtask : test_internal

    task automatic test_external_code();
        access(0, 16'h2000, 8'h00, 8, 8'h7A);
        set_select(1'b0);
        access(0, 16'h0042, 8'h00, 8, 8'h18);
        set_select(1'b1);
    endtask : test_external_code

    task automatic test_data();
        access(2, 16'hABCD, 8'h3C, 8, 8'h00);
        slow = 1'b1;
        access(1, 16'hABCD, 8'h00, 8, 8'h3C);
        access(1, 16'hFFFF, 8'h00, 8, 8'hEE);
        slow = 1'b0;
    endtask : test_data

    task automatic test_ale();
        aleOff = 1'b0;
        repeat (2) @(negedge clock);
        aleCnt = 0;
        repeat (12) @(negedge clock);
        check(16'(aleCnt), 16'h0002);
        aleOff = 1'b1;
        repeat (2) @(negedge clock);
        aleCnt = 0;
        repeat (12) @(negedge clock);
        check(16'(aleCnt), 16'h0000);
        access(1, 16'h1234, 8'h00, 8, 8'hEE);
    endtask : test_ale

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {reset, externalAccessSelect, aleOff, slow} = 4'b1110;
        {codeReq, dataReadReq, dataWriteReq} = 3'b000;
        reqAddress = 16'h0000;
        writeData = 8'h00;
        {n_mismatch, n_checks, cycles} = '0;
        {aleLast, lastWire} = '0;
        repeat (5) @(negedge clock);
        check({addressLatchStrobe, programStoreStrobeN, readStrobeN, writeStrobeN}, 4'h7);
        check(lowPortOeN, 1'b1);
        repeat (MIN_RESET_CLOCKS - 5) @(negedge clock);
        reset = 1'b0;
        repeat (4) @(negedge clock);
        test_internal();
        test_external_code();
        test_data();
        test_ale();
        stop_test();
    end
endmodule : external_memory_bus_interface_tb_top
